// >>> lsrm_pkg.sv
// Package for the low supply reset monitor: offsets, fields, reset values, types
package lsrm_pkg;

  // Register indices (byte address = 4 * index)
  localparam logic [3:0] LSRM_IDX_STATUS  = 4'h0;
  localparam logic [3:0] LSRM_IDX_CONFIG  = 4'h1;
  localparam logic [3:0] LSRM_IDX_IRQSTAT = 4'h2;
  localparam logic [3:0] LSRM_IDX_IRQMASK = 4'h3;

  // Status register field positions
  localparam int LSRM_ST_FLAG_BIT  = 0;
  localparam int LSRM_ST_RESET_BIT = 1;

  // Configuration field positions
  localparam int LSRM_CFG_PWRD_BIT = 0;
  localparam int LSRM_CFG_RSTD_BIT = 1;
  localparam int LSRM_CFG_STOP_BIT = 2;
  localparam int LSRM_CFG_TRIP_BIT = 3;

  // Event status field positions
  localparam int LSRM_EV_FALL_BIT = 0;
  localparam int LSRM_EV_RISE_BIT = 1;

  // Values after reset
  localparam logic [3:0] LSRM_CONFIG_RST = 4'h0;
  localparam logic [1:0] LSRM_EVENT_RST  = 2'h0;
  localparam logic [1:0] LSRM_MASK_RST   = 2'h0;

  // Synchroniser depth
  localparam int LSRM_SYNC_STAGES = 3;

  // Configuration bits
  typedef struct packed {
    logic tripLevelSelect;
    logic stopModeMonitorEnable;
    logic supplyResetDisable;
    logic monitorPowerDisable;
  } lsrm_cfg_s;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lsrm_bus_s;

  // Monitor state
  typedef enum logic [1:0] {
    LSRM_IDLE  = 2'b01,
    LSRM_RESET = 2'b10
  } lsrm_state_e;

endpackage : lsrm_pkg

// >>> low_supply_reset_monitor.sv
// Digital control of the supply monitor: comparator sync, flag, reset request, registers
// Function
// RULE_01 - Monitor is active straight out of reset with default settings.
// RULE_02 - Comparator observed only while monitor power disable is clear.
// RULE_03 - Reset request when powered, resets enabled and supply below falling level.
// RULE_04 - Trip level select chooses 5 V thresholds when set, 3 V when clear.
// RULE_05 - After reset the 3 V trip selection is in use.
// RULE_06 - Selecting 5 V with supply below its rising level resets at once.
// RULE_07 - Reset request held until supply reported above rising level.
// RULE_08 - Flag is 1 below falling, 0 above rising, otherwise keeps value.
// RULE_09 - Any system reset clears the low supply flag.
// RULE_10 - The supply monitor itself never raises an interrupt request; the code raises eventIrq on unmasked flag edges.
// RULE_11 - Enabled monitor keeps working in wait mode and may reset it.
// RULE_12 - In stop mode active only if power disable clear and stop enable set.
// RULE_13 - Powered with resets disabled: flag updates, no reset request.
// RULE_14 - Comparator outputs pass a multi-stage synchroniser before use.
module low_supply_reset_monitor
  import lsrm_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire lsrm_pkg::lsrm_bus_s busReq,
  output logic [7:0]             busRdata,
  input  wire logic              belowFalling5v,
  input  wire logic              aboveRising5v,
  input  wire logic              belowFalling3v,
  input  wire logic              aboveRising3v,
  input  wire logic              waitMode,
  input  wire logic              stopMode,
  output logic                   comparatorEnable,
  output logic                   tripSelect5v,
  output logic                   supplyResetRequest,
  output logic                   lowSupplyFlag,
  output logic                   eventIrq
);
  import lsrm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Two agreeing stages behind a first one need three flops at least
  if (LSRM_SYNC_STAGES < 3) begin : g_sync_depth_check
    $error("synchroniser needs at least three stages");
  end

  // Config register holds exactly the four setting bits
  if ($bits(lsrm_cfg_s) != 4) begin : g_cfg_width_check
    $error("configuration struct must be four bits wide");
  end

  // Register request carries index, data and two strobes
  if ($bits(lsrm_bus_s) != 14) begin : g_bus_width_check
    $error("register request struct must be fourteen bits wide");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration and synchronisers

  lsrm_cfg_s   cfg;
  lsrm_state_e state;
  lsrm_state_e next_state;
  logic [1:0]  eventStatus;
  logic [1:0]  eventMask;
  logic [3:0]  rawCmp;
  logic [3:0]  syncCmp [LSRM_SYNC_STAGES];
  logic        belowFall;
  logic        aboveRise;
  logic        monitorActive;
  logic        prevFlag;
  logic        cfgWrite;
  logic        maskWrite;
  logic        eventRead;
  logic        fallTrip;
  logic        selectTrip;

  // Strobe decode shared by the config, mask and event status registers
  function automatic logic addrHit(input logic strobe, input logic [3:0] addr, input logic [3:0] idx);
    addrHit = strobe && (addr == idx);
  endfunction : addrHit

  assign cfgWrite  = addrHit(busReq.wr, busReq.addr, LSRM_IDX_CONFIG);
  assign maskWrite = addrHit(busReq.wr, busReq.addr, LSRM_IDX_IRQMASK);
  assign eventRead = addrHit(busReq.rd, busReq.addr, LSRM_IDX_IRQSTAT);

  // Clear reset values power the monitor on at 3 V with resets enabled
  // RULE_01 default enabled config
  // RULE_05 3 V after reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg <= lsrm_cfg_s'(LSRM_CONFIG_RST);
    end else if (cfgWrite) begin
      cfg <= lsrm_cfg_s'(busReq.wdata[3:0]);
    end
  end

  // Comparator levels, 5 V pair high, 3 V pair low
  assign rawCmp = {belowFalling5v, aboveRising5v, belowFalling3v, aboveRising3v};

  // RULE_14 three-stage sync
  // Only the later stages are read, never the possibly metastable first flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncCmp[0] <= 4'h0;
    end else begin
      syncCmp[0] <= rawCmp;
    end
  end

  for (genvar s = 1; s < LSRM_SYNC_STAGES; s++) begin : g_sync_stage
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        syncCmp[s] <= 4'h0;
      end else begin
        syncCmp[s] <= syncCmp[s-1];
      end
    end
  end

  // A level counts once stages two and three agree; otherwise hold
  function automatic logic agreed(input logic a, input logic b, input logic old);
    agreed = (a == b) ? a : old;
  endfunction : agreed

  // Agreement stage filters a glitch caught by only one flop
  logic [3:0] cmpStable;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmpStable <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        cmpStable[i] <= agreed(syncCmp[1][i], syncCmp[2][i], cmpStable[i]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Threshold choice and activity

  // Both pairs are synchronised all the time, so a select change needs no resync
  // RULE_04 pick threshold pair
  // RULE_06 5 V pair used the cycle select is set
  assign belowFall = cfg.tripLevelSelect ? cmpStable[3] : cmpStable[1];
  assign aboveRise = cfg.tripLevelSelect ? cmpStable[2] : cmpStable[0];

  // RULE_02 power disable gates monitor
  // RULE_11 wait mode keeps running
  // Wait mode is deliberately left out of the gate
  // RULE_12 stop needs stop enable
  assign monitorActive = !cfg.monitorPowerDisable && (!stopMode || cfg.stopModeMonitorEnable);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // Powered out of reset, so the supply is watched from the first edge
      comparatorEnable <= 1'b1;
      tripSelect5v     <= 1'b0;
    end else begin
      comparatorEnable <= monitorActive;
      tripSelect5v     <= cfg.tripLevelSelect;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Low supply flag

  // RULE_08 hysteresis flag
  // RULE_09 reset clears flag
  // RULE_13 flag kept for polling
  // Inactive monitor freezes the flag rather than trusting idle comparator levels
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lowSupplyFlag <= 1'b0;
    end else if (monitorActive) begin
      if (belowFall) begin
        lowSupplyFlag <= 1'b1;
      end else if (aboveRise) begin
        lowSupplyFlag <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset request machine

  // RULE_03 trip on falling level
  assign fallTrip   = belowFall;
  // RULE_06 5 V chosen while supply under its rising level
  // Registered select still shows the old choice in the cycle after the write
  assign selectTrip = !aboveRise && cfg.tripLevelSelect && !tripSelect5v;

  always_comb begin
    next_state = state;
    unique case (state)
      LSRM_IDLE: begin
        // RULE_13 no reset when disabled
        if (monitorActive && !cfg.supplyResetDisable && (fallTrip || selectTrip)) begin
          next_state = LSRM_RESET;
        end
      end
      LSRM_RESET: begin
        // RULE_07 hold until above rising
        // Needs the rising level, not just the falling level gone
        if (aboveRise) begin
          next_state = LSRM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= LSRM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // RULE_03 request from state
  // RULE_11 reset ends wait mode
  // RULE_12 reset ends stop mode
  // Taken from the next state so the request rises with the flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      supplyResetRequest <= 1'b0;
    end else begin
      supplyResetRequest <= (next_state == LSRM_RESET);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event status and interrupt (rise and fall of the low supply flag)

  // Low supply flag edges; an unmasked edge raises eventIrq
  logic [1:0] evSet;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prevFlag <= 1'b0;
    end else begin
      prevFlag <= lowSupplyFlag;
    end
  end
  // Flag and its copy both clear in reset, so no false edge follows it
  assign evSet = {prevFlag && !lowSupplyFlag, !prevFlag && lowSupplyFlag};

  // Read clears, but a new event in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eventStatus <= LSRM_EVENT_RST;
    end else if (eventRead) begin
      eventStatus <= evSet;
    end else begin
      eventStatus <= eventStatus | evSet;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eventMask <= LSRM_MASK_RST;
    end else if (maskWrite) begin
      eventMask <= busReq.wdata[1:0];
    end
  end

  // RULE_10 mask reset keeps it silent
  // Nothing reaches software until it unmasks an event
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eventIrq <= 1'b0;
    end else begin
      eventIrq <= |(eventStatus & eventMask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port

  // Read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busRdata <= 8'h00;
    end else if (busReq.rd) begin
      unique case (busReq.addr)
        LSRM_IDX_STATUS: begin
          busRdata <= {6'h00, supplyResetRequest, lowSupplyFlag};
        end
        LSRM_IDX_CONFIG: begin
          busRdata <= {4'h0, cfg};
        end
        LSRM_IDX_IRQSTAT: begin
          busRdata <= {6'h00, eventStatus};
        end
        LSRM_IDX_IRQMASK: begin
          busRdata <= {6'h00, eventMask};
        end
        default: begin
          busRdata <= 8'h00;
        end
      endcase
    end else begin
      busRdata <= 8'h00;
    end
  end

endmodule : low_supply_reset_monitor

// >>> lsrm_checker.sv
// Port checks for the low supply reset monitor
module lsrm_checker
  import lsrm_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire lsrm_bus_s  busReq,
  input wire logic [7:0] busRdata,
  input wire logic       belowFalling5v,
  input wire logic       aboveRising5v,
  input wire logic       belowFalling3v,
  input wire logic       aboveRising3v,
  input wire logic       comparatorEnable,
  input wire logic       tripSelect5v,
  input wire logic       supplyResetRequest,
  input wire logic       lowSupplyFlag
);
  import lsrm_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_low3; (comparatorEnable && !tripSelect5v && belowFalling3v)[*8]; endsequence
  sequence s_low5; (comparatorEnable && tripSelect5v && belowFalling5v)[*8]; endsequence
  sequence s_ok3; (comparatorEnable && !tripSelect5v && aboveRising3v)[*8]; endsequence
  property p_rst_clear;
    disable iff (1'b0) rst |=> !lowSupplyFlag && !supplyResetRequest && comparatorEnable && !tripSelect5v;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs wrong after reset");
  property p_flag_set3; s_low3 |-> lowSupplyFlag; endproperty
  a_flag_set3: assert property (p_flag_set3) else $error("flag not set at 3v");
  property p_flag_set5; s_low5 |-> lowSupplyFlag; endproperty
  a_flag_set5: assert property (p_flag_set5) else $error("flag not set at 5v");
  property p_flag_clr; s_ok3 |-> !lowSupplyFlag; endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
  property p_flag_sync; $rose(lowSupplyFlag) |-> $past(belowFalling3v || belowFalling5v, 2); endproperty
  a_flag_sync: assert property (p_flag_sync) else $error("flag rose too early");
  property p_req_fall; $fell(supplyResetRequest) |-> $past(aboveRising3v || aboveRising5v, 2); endproperty
  a_req_fall: assert property (p_req_fall) else $error("request dropped early");
  property p_req_cause;
    $rose(supplyResetRequest) |-> $past(belowFalling3v || belowFalling5v, 2) || tripSelect5v;
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without cause");
  property p_rd_status;
    busReq.rd && busReq.addr == LSRM_IDX_STATUS |=>
      busRdata == {6'h00, $past(supplyResetRequest), $past(lowSupplyFlag)};
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read wrong");
endmodule : lsrm_checker
bind low_supply_reset_monitor lsrm_checker u_chk (.sys_clk(sys_clk), .rst(rst), .busReq(busReq),
  .busRdata(busRdata), .belowFalling5v(belowFalling5v), .aboveRising5v(aboveRising5v),
  .belowFalling3v(belowFalling3v), .aboveRising3v(aboveRising3v), .comparatorEnable(comparatorEnable),
  .tripSelect5v(tripSelect5v), .supplyResetRequest(supplyResetRequest), .lowSupplyFlag(lowSupplyFlag));

// >>> lsrm_supply_model.sv
// Analog comparator model: supply level code to trip decisions
module lsrm_supply_model (
  input  wire logic       sys_clk,
  input  wire logic       comparatorEnable,
  input  wire logic [2:0] supplyLevel,
  output logic            belowFalling5v,
  output logic            aboveRising5v,
  output logic            belowFalling3v,
  output logic            aboveRising3v
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {belowFalling5v, aboveRising5v, belowFalling3v, aboveRising3v} = 4'h5;
  always @(posedge sys_clk)
    if (comparatorEnable) begin
      {belowFalling5v, aboveRising5v} <= {supplyLevel < 3'd3, supplyLevel >= 3'd4};
      {belowFalling3v, aboveRising3v} <= {supplyLevel < 3'd1, supplyLevel >= 3'd2};
    end else begin
      {belowFalling5v, aboveRising5v, belowFalling3v, aboveRising3v} <=
        ~{belowFalling5v, aboveRising5v, belowFalling3v, aboveRising3v};
    end
endmodule : lsrm_supply_model

// >>> low_supply_reset_monitor_tb_top.sv
// Self-checking bench for the low supply reset monitor
module low_supply_reset_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lsrm_pkg::*;
  logic sys_clk, rst, waitMode, stopMode, comparatorEnable, tripSelect5v, expF;
  logic supplyResetRequest, lowSupplyFlag, eventIrq;
  logic belowFalling5v, aboveRising5v, belowFalling3v, aboveRising3v;
  lsrm_bus_s busReq;
  logic [7:0] busRdata;
  logic [2:0] supplyLevel, lvl;
  logic [31:0] seed;
  int nMismatch, testsRun;
  low_supply_reset_monitor DUT (.sys_clk(sys_clk), .rst(rst), .busReq(busReq), .busRdata(busRdata),
    .belowFalling5v(belowFalling5v), .aboveRising5v(aboveRising5v), .belowFalling3v(belowFalling3v),
    .aboveRising3v(aboveRising3v), .waitMode(waitMode), .stopMode(stopMode),
    .comparatorEnable(comparatorEnable), .tripSelect5v(tripSelect5v),
    .supplyResetRequest(supplyResetRequest), .lowSupplyFlag(lowSupplyFlag), .eventIrq(eventIrq));
  lsrm_supply_model u_sup (.sys_clk(sys_clk), .comparatorEnable(comparatorEnable), .supplyLevel(supplyLevel),
    .belowFalling5v(belowFalling5v), .aboveRising5v(aboveRising5v), .belowFalling3v(belowFalling3v),
    .aboveRising3v(aboveRising3v));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Flag with hysteresis at the 3 V pair
  function automatic logic expFlag(input logic [2:0] l, input logic p);
    return (l == 3'd0) ? 1'b1 : (l >= 3'd2) ? 1'b0 : p;
  endfunction : expFlag
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Enable, request, flag
  task automatic st(input logic [2:0] e);
    chk({5'h00, comparatorEnable, supplyResetRequest, lowSupplyFlag}, {5'h00, e});
  endtask : st
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic lv(input logic [2:0] l);
    supplyLevel <= l;
    settle(8);
  endtask : lv
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1;
    chk(busRdata, e);
  endtask : rd
  task automatic completeRun();
    if (nMismatch == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : completeRun
  //////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; busReq = '0; waitMode = 1'b0; stopMode = 1'b0; supplyLevel = 3'd4;
    seed = 32'h50ace72f; nMismatch = 0; testsRun = 0; expF = 1'b0; lvl = 3'd0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    settle(1);
    st(3'h4);
    chk({7'h00, tripSelect5v}, 8'h00);
    rd(LSRM_IDX_CONFIG, 8'h00);
    rd(4'h9, 8'h00);
    wr(LSRM_IDX_STATUS, 8'hff);
    rd(LSRM_IDX_STATUS, 8'h00);
    lv(3'd0); st(3'h7);
    rd(LSRM_IDX_STATUS, 8'h03);
    lv(3'd1); st(3'h7);
    lv(3'd2); st(3'h4);
    chk({7'h00, eventIrq}, 8'h00);
    wr(LSRM_IDX_IRQMASK, 8'h03); settle(2);
    chk({7'h00, eventIrq}, 8'h01);
    rd(LSRM_IDX_IRQSTAT, 8'h03); settle(2);
    chk({7'h00, eventIrq}, 8'h00);
    wr(LSRM_IDX_IRQMASK, 8'h00);
    wr(LSRM_IDX_CONFIG, 8'h02);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      lvl = 3'(seed % 5);
      expF = expFlag(lvl, expF);
      waitMode <= seed[8];
      lv(lvl); st({2'b10, expF});
    end
    waitMode <= 1'b0;
    lv(3'd0); wr(LSRM_IDX_CONFIG, 8'h03);
    lv(3'd4); st(3'h1);
    wr(LSRM_IDX_CONFIG, 8'h02); settle(8); st(3'h4);
    wr(LSRM_IDX_CONFIG, 8'h00); lv(3'd3); st(3'h4);
    wr(LSRM_IDX_CONFIG, 8'h08); settle(1); st(3'h6);
    chk({7'h00, tripSelect5v}, 8'h01);
    lv(3'd2); st(3'h7);
    lv(3'd4); st(3'h4);
    wr(LSRM_IDX_CONFIG, 8'h00);
    stopMode <= 1'b1;
    lv(3'd0); st(3'h0);
    wr(LSRM_IDX_CONFIG, 8'h04); settle(8); st(3'h7);
    lv(3'd2); st(3'h4);
    stopMode <= 1'b0;
    wr(LSRM_IDX_CONFIG, 8'h02); lv(3'd0);
    rst <= 1'b1; settle(1); rst <= 1'b0; settle(1);
    st(3'h4);
    rd(LSRM_IDX_CONFIG, 8'h00);
    completeRun();
  end
endmodule : low_supply_reset_monitor_tb_top
